// *** rtl/art5_pkg.sv ***
// Constants, addresses and field layout shared by the auto-reload timer
package art5_pkg;

	// Register data width
	localparam int ART5_DW = 8;

	// Register addresses on the special function register bus
	localparam logic [7:0] ART5_ADDR_CONTROL = 8'hC8;
	localparam logic [7:0] ART5_ADDR_RELOAD_LOW = 8'hCA;
	localparam logic [7:0] ART5_ADDR_RELOAD_HIGH = 8'hCB;
	localparam logic [7:0] ART5_ADDR_COUNT_LOW = 8'hCC;
	localparam logic [7:0] ART5_ADDR_COUNT_HIGH = 8'hCD;

	// Control register field positions
	localparam int ART5_BIT_HIGH_FLAG = 7;
	localparam int ART5_BIT_LOW_FLAG = 6;
	localparam int ART5_BIT_LOW_IRQ_EN = 5;
	localparam int ART5_BIT_SPLIT = 3;
	localparam int ART5_BIT_RUN = 2;
	localparam int ART5_BIT_EXT_SEL = 0;

	// Reset values
	localparam logic [7:0] ART5_CONTROL_RESET = 8'h00;
	localparam logic [7:0] ART5_BYTE_RESET = 8'h00;
	localparam logic [7:0] ART5_READ_ZERO = 8'h00;

	// Count limits
	localparam logic [7:0] ART5_BYTE_MAX = 8'hFF;
	localparam logic [7:0] ART5_BYTE_ONE = 8'h01;

	// Prescaler for the divided system clock
	localparam int ART5_SYS_DIV = 12;
	localparam logic [3:0] ART5_SYS_DIV_LAST = 4'(ART5_SYS_DIV - 1);
	localparam logic [3:0] ART5_SYS_DIV_ZERO = 4'h0;
	localparam logic [3:0] ART5_SYS_DIV_STEP = 4'h1;

	// Divider for the synchronized external oscillator
	localparam int ART5_EXT_DIV = 8;
	localparam logic [2:0] ART5_EXT_DIV_LAST = 3'(ART5_EXT_DIV - 1);
	localparam logic [2:0] ART5_EXT_DIV_ZERO = 3'h0;
	localparam logic [2:0] ART5_EXT_DIV_STEP = 3'h1;

endpackage : art5_pkg

// *** rtl/art5_tick_if.sv ***
// Interface carrying the prescaled tick enables to the timer core
`timescale 1ns/1ps
interface art5_tick_if;
	// One-cycle enable every twelfth system clock
	logic div12_tick;
	// One-cycle enable every eighth synchronized external edge
	logic ext8_tick;

	// Tick source side
	modport src (output div12_tick, output ext8_tick);
	// Tick consumer side
	modport dst (input div12_tick, input ext8_tick);
endinterface : art5_tick_if

// *** rtl/art5_tick_gen.sv ***
// Prescaler for the divided system clock and the synchronized external clock
`timescale 1ns/1ps
module art5_tick_gen
	import art5_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// External oscillator pin, asynchronous
	input wire logic i_ext_osc,
	// Tick enables out
	art5_tick_if.src ticks
);

	logic [3:0] sys_div; // Divide-by-twelve phase
	logic ext_meta; // First synchroniser stage
	logic ext_sync; // Second synchroniser stage
	logic ext_prev; // Delayed copy for edge detection
	logic [2:0] ext_div; // Divide-by-eight phase
	wire ext_rise = ext_sync & ~ext_prev; // Rising edge of the synced oscillator
	wire sys_wrap = (sys_div == ART5_SYS_DIV_LAST); // Last phase of twelve

	// Single-cycle tick pulses for the divided sources
	assign ticks.div12_tick = sys_wrap;
	assign ticks.ext8_tick = ext_rise & (ext_div == ART5_EXT_DIV_LAST);

	// System clock divided by twelve
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sys_div <= ART5_SYS_DIV_ZERO;
		end else begin
			sys_div <= sys_wrap ? ART5_SYS_DIV_ZERO : sys_div + ART5_SYS_DIV_STEP;
		end
	end

	// External oscillator synchronised, then divided by eight
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_prev <= 1'b0;
			ext_div <= ART5_EXT_DIV_ZERO;
		end else begin
			ext_meta <= i_ext_osc;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
			if (ext_rise) begin
				ext_div <= ext_div + ART5_EXT_DIV_STEP;
			end
		end
	end

endmodule // art5_tick_gen

// *** rtl/art5_byte_counter.sv ***
// One eight-bit count byte with software load, increment and reload
`timescale 1ns/1ps
module art5_byte_counter
	import art5_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// Software write of the count value
	input wire logic i_write,
	input wire logic [7:0] i_write_value,
	// Counting controls
	input wire logic i_increment,
	input wire logic i_reload,
	input wire logic [7:0] i_reload_value,
	// Count state
	output logic [7:0] o_count,
	output logic o_at_max
);

	logic [7:0] next_count; // Value for the next edge

	// Terminal count seen by the wrap logic
	assign o_at_max = (o_count == ART5_BYTE_MAX);

	// Software write wins, then reload, then plain increment
	always_comb begin
		next_count = o_count;
		if (i_write) begin
			next_count = i_write_value;
		end else if (i_reload) begin
			next_count = i_reload_value;
		end else if (i_increment) begin
			next_count = o_count + ART5_BYTE_ONE;
		end
	end

	// Count register, cleared by reset
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_count <= ART5_BYTE_RESET;
		end else begin
			o_count <= next_count;
		end
	end

endmodule // art5_byte_counter

// *** rtl/art5_timer.sv ***
// Auto-reload timer top: register port, mode logic, flags and interrupt request
`timescale 1ns/1ps

// Functional notes
// - Two eight-bit bytes form one 16-bit counter
// - Clock: system, system/12, or synced external/8
// - Split bit clear gives 16-bit auto-reload
// - 16-bit wrap loads reload bytes, sets high flag
// - Timer irq enable: interrupt on high flag
// - 16-bit: low irq enable adds low-byte interrupts
// - Split, capture off: two eight-bit auto-reload counters
// - Split: run bit gates high byte only
// - Split: per-byte select plus shared external select
// - Flags set on each byte's wrap
// - Split: interrupt on either byte when enabled
// - Only software clears the overflow flags
// - Control bits 7,6,5,3; bit 4 reads zero
// - Bit 2 run, bit 1 zero, bit 0 external
module art5_timer
	import art5_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// Special function register port
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_write,
	input wire logic i_sfr_read,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	// Clock selection bits held in the system clock-select register
	input wire logic i_high_byte_clock_select,
	input wire logic i_low_byte_clock_select,
	// Capture enable bit from outside this block
	input wire logic i_capture_enable_bit,
	// Timer interrupt enable from the extended interrupt-enable register
	input wire logic i_timer_irq_enable,
	// External oscillator pin
	input wire logic i_ext_osc,
	// Interrupt request to the interrupt controller
	output logic o_irq_request
);

	// Pick the tick for one byte from its select and the shared external select
	function automatic logic art5_pick_tick(
		input logic sel_sys,
		input logic sel_ext,
		input logic div12_tick,
		input logic ext8_tick
	);
		logic picked;
		picked = sel_sys ? 1'b1 : (sel_ext ? ext8_tick : div12_tick);
		return picked;
	endfunction

	// True when the bus address names the given register
	function automatic logic art5_addr_hit(
		input logic [7:0] addr,
		input logic [7:0] target
	);
		logic hit;
		hit = (addr == target);
		return hit;
	endfunction

	// A byte wraps when it steps while at its terminal count
	function automatic logic art5_wraps(
		input logic step,
		input logic at_max
	);
		logic wraps;
		wraps = step & at_max;
		return wraps;
	endfunction

	// Control byte as read back, built from the named field positions
	function automatic logic [7:0] art5_control_byte(
		input logic high_flag,
		input logic low_flag,
		input logic low_irq_en,
		input logic split,
		input logic run,
		input logic ext_sel
	);
		logic [7:0] ctl_byte;
		ctl_byte = ART5_READ_ZERO; // Unused bits 4 and 1 stay zero
		ctl_byte[ART5_BIT_HIGH_FLAG] = high_flag;
		ctl_byte[ART5_BIT_LOW_FLAG] = low_flag;
		ctl_byte[ART5_BIT_LOW_IRQ_EN] = low_irq_en;
		ctl_byte[ART5_BIT_SPLIT] = split;
		ctl_byte[ART5_BIT_RUN] = run;
		ctl_byte[ART5_BIT_EXT_SEL] = ext_sel;
		return ctl_byte;
	endfunction

	// Control register storage
	logic high_overflow_flag; // Set on high-byte wrap
	logic low_overflow_flag; // Set on low-byte wrap
	logic low_byte_irq_enable; // Adds low-byte interrupts
	logic split_mode_bit; // Two eight-bit timers when set with capture off; both bytes hold with capture on
	logic run_control_bit; // Run gate
	logic external_clock_select; // External/8 instead of system/12

	// Reload bytes
	logic [7:0] reload_low_byte; // Reload value for the low byte
	logic [7:0] reload_high_byte; // Reload value for the high byte

	// The two count bytes are read separately, so a carry may fall between two reads
	// Count bytes, held inside the byte counters
	logic [7:0] count_low_byte; // Low count byte
	logic [7:0] count_high_byte; // High count byte
	logic low_at_max; // Low byte at 0xFF
	logic high_at_max; // High byte at 0xFF

	// Next values of the flags
	logic next_high_flag; // High flag for the next edge
	logic next_low_flag; // Low flag for the next edge

	// Tick enables from the prescaler
	art5_tick_if ticks ();

	// Divided sources arrive as one-cycle enables; every register stays on the system clock
	// Prescaler and external clock synchroniser
	art5_tick_gen u_tick_gen (
		.i_core_clk (i_core_clk),
		.i_sys_rst (i_sys_rst),
		.i_ext_osc (i_ext_osc),
		.ticks (ticks)
	);

	// Register selects shared by the write and read paths
	wire sel_control = art5_addr_hit(i_sfr_addr, ART5_ADDR_CONTROL);
	wire sel_reload_low = art5_addr_hit(i_sfr_addr, ART5_ADDR_RELOAD_LOW);
	wire sel_reload_high = art5_addr_hit(i_sfr_addr, ART5_ADDR_RELOAD_HIGH);
	wire sel_count_low = art5_addr_hit(i_sfr_addr, ART5_ADDR_COUNT_LOW);
	wire sel_count_high = art5_addr_hit(i_sfr_addr, ART5_ADDR_COUNT_HIGH);

	// Address decode for writes
	// An unmapped write matches no select and is dropped
	wire wr_control = i_sfr_write & sel_control;
	wire wr_reload_low = i_sfr_write & sel_reload_low;
	wire wr_reload_high = i_sfr_write & sel_reload_high;
	wire wr_count_low = i_sfr_write & sel_count_low;
	wire wr_count_high = i_sfr_write & sel_count_high;

	// Mode decode; split mode with capture enabled is not a counting mode of this block,
	// so both bytes then hold their value
	wire mode_16bit = ~split_mode_bit;
	wire mode_split = split_mode_bit & ~i_capture_enable_bit;

	// Tick for the low byte, also used for the whole counter in 16-bit mode
	// The high byte select only matters in split mode
	wire low_tick = art5_pick_tick(i_low_byte_clock_select, external_clock_select,
		ticks.div12_tick, ticks.ext8_tick);
	// Tick for the high byte in split mode
	wire high_tick = art5_pick_tick(i_high_byte_clock_select, external_clock_select,
		ticks.div12_tick, ticks.ext8_tick);

	// Low byte steps in 16-bit mode when running, always in split mode
	wire low_inc_16 = mode_16bit & run_control_bit & low_tick;
	wire low_inc_split = mode_split & low_tick;
	wire low_inc = low_inc_16 | low_inc_split;

	// High byte carries from the low byte, or runs on its own tick in split mode
	// The carry comes from the low byte's own step, so both bytes move on one edge
	wire high_inc_16 = art5_wraps(low_inc_16, low_at_max);
	wire high_inc_split = mode_split & run_control_bit & high_tick;
	wire high_inc = high_inc_16 | high_inc_split;

	// Wrap events of each byte
	wire low_wrap = art5_wraps(low_inc, low_at_max);
	wire high_wrap = art5_wraps(high_inc, high_at_max);

	// Full 16-bit wrap reloads both bytes together
	wire wrap_16 = mode_16bit & high_wrap;
	wire reload_low_now = wrap_16 | (mode_split & low_wrap);
	wire reload_high_now = wrap_16 | (mode_split & high_wrap);

	// A software count write beats a reload or a step in the same cycle
	// Low count byte
	art5_byte_counter u_low_byte (
		.i_core_clk (i_core_clk),
		.i_sys_rst (i_sys_rst),
		.i_write (wr_count_low),
		.i_write_value (i_sfr_wdata),
		.i_increment (low_inc),
		.i_reload (reload_low_now),
		.i_reload_value (reload_low_byte),
		.o_count (count_low_byte),
		.o_at_max (low_at_max)
	);

	// High count byte
	art5_byte_counter u_high_byte (
		.i_core_clk (i_core_clk),
		.i_sys_rst (i_sys_rst),
		.i_write (wr_count_high),
		.i_write_value (i_sfr_wdata),
		.i_increment (high_inc),
		.i_reload (reload_high_now),
		.i_reload_value (reload_high_byte),
		.o_count (count_high_byte),
		.o_at_max (high_at_max)
	);

	// The flags share the control register, so any control write also writes them;
	// software that wants to keep a flag writes it back as one
	// Flag update: a wrap in the cycle of a software write still sets the flag
	always_comb begin
		next_high_flag = high_overflow_flag;
		next_low_flag = low_overflow_flag;
		// Software may write either value; hardware never clears
		if (wr_control) begin
			next_high_flag = i_sfr_wdata[ART5_BIT_HIGH_FLAG];
			next_low_flag = i_sfr_wdata[ART5_BIT_LOW_FLAG];
		end
		// Set wins over a simultaneous clear
		if (high_wrap) begin
			next_high_flag = 1'b1;
		end
		if (low_wrap) begin
			next_low_flag = 1'b1;
		end
	end

	// Overflow flags
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			high_overflow_flag <= ART5_CONTROL_RESET[ART5_BIT_HIGH_FLAG];
			low_overflow_flag <= ART5_CONTROL_RESET[ART5_BIT_LOW_FLAG];
		end else begin
			high_overflow_flag <= next_high_flag;
			low_overflow_flag <= next_low_flag;
		end
	end

	// Writable control fields; bits 4 and 1 have no storage
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			low_byte_irq_enable <= ART5_CONTROL_RESET[ART5_BIT_LOW_IRQ_EN];
			split_mode_bit <= ART5_CONTROL_RESET[ART5_BIT_SPLIT];
			run_control_bit <= ART5_CONTROL_RESET[ART5_BIT_RUN];
			external_clock_select <= ART5_CONTROL_RESET[ART5_BIT_EXT_SEL];
		end else if (wr_control) begin
			low_byte_irq_enable <= i_sfr_wdata[ART5_BIT_LOW_IRQ_EN];
			split_mode_bit <= i_sfr_wdata[ART5_BIT_SPLIT];
			run_control_bit <= i_sfr_wdata[ART5_BIT_RUN];
			external_clock_select <= i_sfr_wdata[ART5_BIT_EXT_SEL];
		end
	end

	// A new reload value is used from the first wrap after its write edge;
	// a wrap on the write edge itself still loads the old value
	// Reload bytes, plain read/write storage
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			reload_low_byte <= ART5_BYTE_RESET;
			reload_high_byte <= ART5_BYTE_RESET;
		end else begin
			if (wr_reload_low) begin
				reload_low_byte <= i_sfr_wdata;
			end
			if (wr_reload_high) begin
				reload_high_byte <= i_sfr_wdata;
			end
		end
	end

	// Control register as read back; unused bits are zero
	wire [7:0] control_view = art5_control_byte(high_overflow_flag, low_overflow_flag, low_byte_irq_enable,
		split_mode_bit, run_control_bit, external_clock_select);

	// Read selection; unmapped addresses read zero
	// A read beside a write in one cycle sees the value from before the write
	wire [7:0] read_select =
		sel_control ? control_view :
		sel_reload_low ? reload_low_byte :
		sel_reload_high ? reload_high_byte :
		sel_count_low ? count_low_byte :
		sel_count_high ? count_high_byte :
		ART5_READ_ZERO;

	// Read data register, loaded on a read strobe
	// Registered, so data follows the strobe by one cycle and then stands
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_sfr_rdata <= ART5_READ_ZERO;
		end else if (i_sfr_read) begin
			o_sfr_rdata <= read_select;
		end
	end

	// Interrupt request: high flag always, low flag when its enable is set
	// With low-byte interrupts on, the handler reads both flags to tell the source;
	// the request stays high until software clears the flag that caused it
	wire irq_from_high = high_overflow_flag;
	wire irq_from_low = low_byte_irq_enable & low_overflow_flag;

	// Level request held until software clears the causing flag
	assign o_irq_request = i_timer_irq_enable & (irq_from_high | irq_from_low);

endmodule // art5_timer

// *** bench/art5_timer_asserts.sv ***
// Concurrent checks on the register port and interrupt request of the timer
`timescale 1ns/1ps
module art5_timer_asserts
	import art5_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// Register port
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_write,
	input wire logic i_sfr_read,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic [7:0] o_sfr_rdata,
	// Interrupt enable and request
	input wire logic i_timer_irq_enable,
	input wire logic o_irq_request
);
	// Control address decode
	wire ctl_sel = (i_sfr_addr == ART5_ADDR_CONTROL);
	// Reload address decode
	wire rl_sel = (i_sfr_addr == ART5_ADDR_RELOAD_LOW) || (i_sfr_addr == ART5_ADDR_RELOAD_HIGH);
	// Any mapped address
	wire mapped = ctl_sel || rl_sel || (i_sfr_addr == ART5_ADDR_COUNT_LOW) || (i_sfr_addr == ART5_ADDR_COUNT_HIGH);
	// Plain control read with no write beside it
	wire ctl_rd = i_sfr_read && !i_sfr_write && ctl_sel;

	// One clock and one reset for every check
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);

	property p_rdata_hold;
		!i_sfr_read |=> $stable(o_sfr_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

	property p_unmapped_zero;
		i_sfr_read && !mapped |=> o_sfr_rdata == ART5_READ_ZERO;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

	property p_ctl_unused;
		i_sfr_read && ctl_sel |=> !o_sfr_rdata[4] && !o_sfr_rdata[1];
	endproperty
	a_ctl_unused: assert property (p_ctl_unused) else $error("unused control bit read as one");

	property p_ctl_readback;
		(i_sfr_write && ctl_sel) ##1 !i_sfr_write ##1 ctl_rd |=> (o_sfr_rdata & 8'h2D) == ($past(i_sfr_wdata, 3) & 8'h2D);
	endproperty
	a_ctl_readback: assert property (p_ctl_readback) else $error("control bits not kept");

	property p_reload_readback;
		(i_sfr_write && rl_sel) ##1 !i_sfr_write ##1 (i_sfr_read && !i_sfr_write && i_sfr_addr == $past(i_sfr_addr, 2))
		|=> o_sfr_rdata == $past(i_sfr_wdata, 3);
	endproperty
	a_reload_readback: assert property (p_reload_readback) else $error("reload byte not kept");

	property p_irq_gate;
		!i_timer_irq_enable |-> !o_irq_request;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("request without timer enable");

	property p_high_irq;
		ctl_rd ##1 (o_sfr_rdata[7] && i_timer_irq_enable) |-> o_irq_request;
	endproperty
	a_high_irq: assert property (p_high_irq) else $error("high flag set but no request");

	property p_low_irq;
		ctl_rd ##1 (o_sfr_rdata[6] && o_sfr_rdata[5] && i_timer_irq_enable) |-> o_irq_request;
	endproperty
	a_low_irq: assert property (p_low_irq) else $error("enabled low flag set but no request");

	property p_flag_sticky;
		$fell(o_irq_request) |-> !i_timer_irq_enable || $past(i_sfr_write && ctl_sel);
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("request dropped without software");
endmodule // art5_timer_asserts

bind art5_timer art5_timer_asserts u_asserts (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
	.i_sfr_addr(i_sfr_addr), .i_sfr_write(i_sfr_write), .i_sfr_read(i_sfr_read), .i_sfr_wdata(i_sfr_wdata),
	.o_sfr_rdata(o_sfr_rdata), .i_timer_irq_enable(i_timer_irq_enable), .o_irq_request(o_irq_request));

// *** bench/art5_timer_bench.sv ***
// Self-checking bench for the auto-reload timer
`timescale 1ns/1ps
module art5_timer_bench
	import art5_pkg::*;
;
	// Clock, reset and register port drives
	logic i_core_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [7:0] i_sfr_addr = 8'h00;
	logic i_sfr_write = 1'b0;
	logic i_sfr_read = 1'b0;
	logic [7:0] i_sfr_wdata = 8'h00;
	// Side inputs
	logic hi_sel = 1'b0;
	logic lo_sel = 1'b0;
	logic cap_en = 1'b1;
	logic irq_en = 1'b0;
	logic ext_osc = 1'b0;
	// Observed outputs
	logic [7:0] o_sfr_rdata;
	logic o_irq_request;
	// Tallies and scratch
	int err_total = 0;
	int total_checks = 0;
	logic [7:0] rv;

	// Device under test
	art5_timer u_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_sfr_addr(i_sfr_addr),
		.i_sfr_write(i_sfr_write), .i_sfr_read(i_sfr_read), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
		.i_high_byte_clock_select(hi_sel), .i_low_byte_clock_select(lo_sel), .i_capture_enable_bit(cap_en),
		.i_timer_irq_enable(irq_en), .i_ext_osc(ext_osc), .o_irq_request(o_irq_request));

	// 100 ns system clock
	initial begin
		forever #50 i_core_clk = ~i_core_clk;
	end

	// Wait a number of edges
	task automatic run(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_sfr_addr <= a;
		i_sfr_wdata <= d;
		i_sfr_write <= 1'b1;
		@(posedge i_core_clk);
		i_sfr_write <= 1'b0;
	endtask

	// One-cycle read strobe, data taken after the edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		i_sfr_addr <= a;
		i_sfr_read <= 1'b1;
		@(posedge i_core_clk);
		i_sfr_read <= 1'b0;
		#1;
		d = o_sfr_rdata;
	endtask

	// Byte compare
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	// Read and compare
	task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
		rd(a, rv);
		chk(n, e, rv);
	endtask

	// Request compare at mid-cycle
	task automatic ichk(input string n, input logic e);
		@(negedge i_core_clk);
		chk(n, {7'h00, e}, {7'h00, o_irq_request});
	endtask

	// Verdict and end of run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		run(6);
		i_sys_rst <= 1'b0;
		rchk("control", ART5_ADDR_CONTROL, 8'h00);
		rchk("reload low", ART5_ADDR_RELOAD_LOW, 8'h00);
		rchk("reload high", ART5_ADDR_RELOAD_HIGH, 8'h00);
		rchk("count low", ART5_ADDR_COUNT_LOW, 8'h00);
		rchk("count high", ART5_ADDR_COUNT_HIGH, 8'h00);
		rchk("unmapped", 8'hC9, 8'h00);
		// Split with capture on holds both bytes while fields are written
		wr(ART5_ADDR_CONTROL, 8'hFF);
		rchk("control bits", ART5_ADDR_CONTROL, 8'hED);
		ichk("request gated", 1'b0);
		wr(ART5_ADDR_CONTROL, 8'h00);
		rchk("flags cleared", ART5_ADDR_CONTROL, 8'h00);
		$display("end reset and fields");
		// 16-bit wrap on the system clock
		@(posedge i_core_clk);
		cap_en <= 1'b0;
		lo_sel <= 1'b1;
		hi_sel <= 1'b1;
		irq_en <= 1'b1;
		wr(ART5_ADDR_RELOAD_LOW, 8'h34);
		wr(ART5_ADDR_RELOAD_HIGH, 8'h12);
		rchk("reload kept", ART5_ADDR_RELOAD_HIGH, 8'h12);
		wr(ART5_ADDR_COUNT_LOW, 8'hFE);
		wr(ART5_ADDR_COUNT_HIGH, 8'hFF);
		wr(ART5_ADDR_CONTROL, 8'h04);
		run(3);
		ichk("wrap request", 1'b1);
		rchk("wrap flags", ART5_ADDR_CONTROL, 8'hC4);
		wr(ART5_ADDR_CONTROL, 8'h00);
		rchk("reloaded high", ART5_ADDR_COUNT_HIGH, 8'h12);
		ichk("request cleared", 1'b0);
		// Low-byte wrap, masked then enabled
		wr(ART5_ADDR_COUNT_LOW, 8'hFE);
		wr(ART5_ADDR_CONTROL, 8'h04);
		run(4);
		ichk("low masked", 1'b0);
		rchk("low flag", ART5_ADDR_CONTROL, 8'h44);
		wr(ART5_ADDR_CONTROL, 8'h24);
		wr(ART5_ADDR_COUNT_LOW, 8'hFE);
		run(4);
		ichk("low request", 1'b1);
		rchk("low enabled", ART5_ADDR_CONTROL, 8'h64);
		$display("end 16-bit mode");
		// Split mode: low free-running, high gated by run
		wr(ART5_ADDR_CONTROL, 8'h08);
		wr(ART5_ADDR_COUNT_HIGH, 8'h50);
		wr(ART5_ADDR_RELOAD_LOW, 8'h80);
		wr(ART5_ADDR_COUNT_LOW, 8'hFE);
		run(4);
		rchk("high held", ART5_ADDR_COUNT_HIGH, 8'h50);
		rchk("split low flag", ART5_ADDR_CONTROL, 8'h48);
		ichk("split low masked", 1'b0);
		wr(ART5_ADDR_COUNT_HIGH, 8'hFE);
		wr(ART5_ADDR_RELOAD_HIGH, 8'h77);
		wr(ART5_ADDR_CONTROL, 8'h0C);
		run(4);
		ichk("split high request", 1'b1);
		wr(ART5_ADDR_CONTROL, 8'h08);
		rd(ART5_ADDR_COUNT_HIGH, rv);
		chk("high reload", 8'h7B, rv);
		rd(ART5_ADDR_COUNT_LOW, rv);
		chk("low reload", 8'h01, {7'h00, rv[7]});
		$display("end split mode");
		// Split high byte on system/12 while the low byte runs on the system clock
		@(posedge i_core_clk);
		hi_sel <= 1'b0;
		wr(ART5_ADDR_COUNT_HIGH, 8'h00);
		wr(ART5_ADDR_CONTROL, 8'h0C);
		run(58);
		wr(ART5_ADDR_CONTROL, 8'h08);
		rchk("split div12 high", ART5_ADDR_COUNT_HIGH, 8'h05);
		// Divide by 12 over 120 edges
		lo_sel <= 1'b0;
		wr(ART5_ADDR_CONTROL, 8'h00);
		wr(ART5_ADDR_COUNT_LOW, 8'h00);
		wr(ART5_ADDR_CONTROL, 8'h04);
		run(118);
		wr(ART5_ADDR_CONTROL, 8'h00);
		rchk("div12 count", ART5_ADDR_COUNT_LOW, 8'h0A);
		// External oscillator divided by 8
		wr(ART5_ADDR_COUNT_LOW, 8'h00);
		wr(ART5_ADDR_CONTROL, 8'h05);
		repeat (16) begin
			@(posedge i_core_clk);
			ext_osc <= 1'b1;
			run(2);
			ext_osc <= 1'b0;
			run(2);
		end
		run(10);
		wr(ART5_ADDR_CONTROL, 8'h01);
		rchk("ext8 count", ART5_ADDR_COUNT_LOW, 8'h02);
		$display("end clock sources");
		stop_test();
	end

	// Watchdog well beyond the expected run time
	initial begin
		#500000;
		err_total++;
		$display("watchdog expired");
		stop_test();
	end
endmodule // art5_timer_bench
